// [inc/isrc_map.vh]
// register offsets, field positions, reset values and bus response codes for isrc
`ifndef ISRC_MAP_VH
`define ISRC_MAP_VH
// byte offsets on the register bus
`define ISRC_OFF_CAUSE      12'h000
`define ISRC_OFF_CTRL_A     12'h004
`define ISRC_OFF_CTRL_B     12'h008
`define ISRC_OFF_CTRL_C     12'h00C
`define ISRC_OFF_CHG_EN     12'h010
`define ISRC_OFF_TMR_LO     12'h014
`define ISRC_OFF_TMR_HI     12'h018
`define ISRC_OFF_TMR_CFG    12'h01C
`define ISRC_OFF_CORE       12'h020
`define ISRC_OFF_SHADOW     12'h024
`define ISRC_OFF_RET_PC     12'h028
// reset_cause_and_priority fields
`define ISRC_RC_PRIO        7
`define ISRC_RC_SBOR        6
`define ISRC_RC_UNUSED      5
`define ISRC_RC_SWRST       4
`define ISRC_RC_WDOG        3
`define ISRC_RC_SLEEP       2
`define ISRC_RC_POR         1
`define ISRC_RC_BOR         0
// irq_control_a fields
`define ISRC_A_GIE          7
`define ISRC_A_PERIPHERAL_IRQ_GATE         6
`define ISRC_A_T0IE         5
`define ISRC_A_INT0E        4
`define ISRC_A_PCE          3
`define ISRC_A_T0IF         2
`define ISRC_A_INT0F        1
`define ISRC_A_PCF          0
// irq_control_b fields
`define ISRC_B_EDGE0        6
`define ISRC_B_EDGE1        5
`define ISRC_B_EDGE2        4
`define ISRC_B_T0IP         2
`define ISRC_B_PCIP         0
// irq_control_c fields
`define ISRC_C_EXT_TWO_PRIORITY       7
`define ISRC_C_EXT_ONE_PRIORITY       6
`define ISRC_C_INT2E        4
`define ISRC_C_INT1E        3
`define ISRC_C_INT2F        1
`define ISRC_C_INT1F        0
// timer config and core control fields
`define ISRC_TC_WIDE        0
`define ISRC_TC_RUN         1
`define ISRC_CORE_SLEEP     0
// reset values and bus response codes
`define ISRC_RST_CTRL_B     8'h7F
`define ISRC_RST_CTRL_C     8'hC0
`define ISRC_RST_TMR_CFG    8'h00
`define ISRC_RESP_OKAY      2'b00
`define ISRC_RESP_SLVERR    2'b10
`endif

// [core/isrc_sync_edge.v]
// two-stage pin synchroniser with change detection for isrc
`timescale 1ns/1ps
module isrc_sync_edge #(
    parameter W = 7
) (
    clk_sys,
    rstn,
    pin_async,
    pin_level,
    pin_rise,
    pin_fall
);
    input  wire         clk_sys;
    input  wire         rstn;
    input  wire [W-1:0] pin_async;  // raw pins
    output wire [W-1:0] pin_level;  // synchronised level
    output wire [W-1:0] pin_rise;   // one-cycle rising pulse
    output wire [W-1:0] pin_fall;   // one-cycle falling pulse

    reg [W-1:0] meta_reg;   // first stage, read only by sync_reg
    reg [W-1:0] sync_reg;   // second stage
    reg [W-1:0] last_reg;   // previous synchronised level

    // sync chain; edges are judged on stage two against stage three
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
            last_reg <= {W{1'b0}};
        end else begin
            meta_reg <= pin_async;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign pin_level = sync_reg;
    assign pin_rise  = sync_reg & ~last_reg;
    assign pin_fall  = ~sync_reg & last_reg;
endmodule // isrc_sync_edge

// [core/isrc_top.v]
// interrupt sources, reset cause register and context save for isrc
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "isrc_map.vh"

module isrc_top #(
    parameter PC_W  = 21,
    parameter STK_D = 31
) (
    input  wire            clk_sys,
    input  wire            rstn,
    input  wire            por_event,    // this reset came from power-on
    input  wire            bor_default,  // configured brown-out enable
    input  wire            reset_instr,  // core executed reset instruction
    input  wire            wdog_expired, // watchdog pulse
    input  wire [2:0]      ext_pins,     // ext_irq_zero..two pins
    input  wire [3:0]      port_b_hi,    // port-B pins 7..4
    input  wire            timer_tick,   // timer increment pulse
    input  wire [PC_W-1:0] core_pc,      // return address
    input  wire [7:0]      core_acc,     // working_accumulator
    input  wire [7:0]      core_status,  // status register
    input  wire [7:0]      core_bank,    // bank_select_reg
    input  wire            irq_ack,      // core enters interrupt
    input  wire [11:0]     s_axi_awaddr,
    input  wire            s_axi_awvalid,
    output reg             s_axi_awready,
    input  wire [31:0]     s_axi_wdata,
    input  wire [3:0]      s_axi_wstrb,
    input  wire            s_axi_wvalid,
    output reg             s_axi_wready,
    output reg  [1:0]      s_axi_bresp,
    output reg             s_axi_bvalid,
    input  wire            s_axi_bready,
    input  wire [11:0]     s_axi_araddr,
    input  wire            s_axi_arvalid,
    output reg             s_axi_arready,
    output reg  [31:0]     s_axi_rdata,
    output reg  [1:0]      s_axi_rresp,
    output reg             s_axi_rvalid,
    input  wire            s_axi_rready,
    output reg             irq_high,     // high-priority request
    output reg             irq_low,      // low-priority request
    output reg             wake_req,     // wake core from idle/sleep
    output reg             vector_take   // core should vector on wake
);

    // software-visible control
    reg  [7:0]      rc_reg;       // reset_cause_and_priority
    reg  [7:0]      ca_reg;       // irq_control_a
    reg  [7:0]      cb_reg;       // irq_control_b
    reg  [7:0]      cc_reg;       // irq_control_c
    reg  [3:0]      chg_en_reg;   // change_pin_enables
    reg  [15:0]     tmr_reg;      // timer_zero_count pair
    reg  [7:0]      tcfg_reg;     // width and run control
    reg             sleep_reg;    // core is idle/sleeping
    reg             boot_reg;     // first cycle after reset release
    reg  [23:0]     shadow_reg;   // fast shadow stack
    reg  [PC_W-1:0] stack_mem [0:STK_D-1]; // hardware return stack
    reg  [4:0]      sp_reg;       // stack depth
    reg  [11:0]     waddr_reg;
    reg  [31:0]     wdata_reg;
    reg  [3:0]      wstrb_reg;
    reg             aw_ok_reg;    // address held
    reg             w_ok_reg;     // data held

    wire [6:0] rise;
    wire [6:0] fall;

    // pins 0..2 external, 3..6 upper port-B
    isrc_sync_edge #(.W(7)) u_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .pin_async ({port_b_hi, ext_pins}),
        .pin_level (),
        .pin_rise  (rise),
        .pin_fall  (fall)
    );

    // pick rising when edge select is one, else falling
    function edge_hit;
        input sel;
        input r;
        input f;
        begin
            edge_hit = sel ? r : f;
        end
    endfunction

    // byte-lane merge for register writes
    function [7:0] lane;
        input [7:0] old;
        input [7:0] nw;
        input       en;
        begin
            lane = en ? nw : old;
        end
    endfunction

    wire hit0 = edge_hit(cb_reg[`ISRC_B_EDGE0], rise[0], fall[0]);
    wire hit1 = edge_hit(cb_reg[`ISRC_B_EDGE1], rise[1], fall[1]);
    wire hit2 = edge_hit(cb_reg[`ISRC_B_EDGE2], rise[2], fall[2]);
    // only enabled upper pins count as a change
    wire chg_hit = |((rise[6:3] | fall[6:3]) & chg_en_reg);

    wire wide = tcfg_reg[`ISRC_TC_WIDE];
    wire run  = tcfg_reg[`ISRC_TC_RUN] & timer_tick;
    // rollover at all-ones in the chosen width
    wire tmr_ovf = run & (wide ? (tmr_reg == 16'hFFFF)
                               : (tmr_reg[7:0] == 8'hFF));

    // bus handshakes
    wire wr_go = aw_ok_reg & w_ok_reg & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire [31:0] wd = wdata_reg;
    wire wl = wstrb_reg[0];
    wire wr_rc  = wr_go & (waddr_reg == `ISRC_OFF_CAUSE);
    wire wr_ca  = wr_go & (waddr_reg == `ISRC_OFF_CTRL_A);
    wire wr_cc  = wr_go & (waddr_reg == `ISRC_OFF_CTRL_C);
    wire wr_tl  = wr_go & (waddr_reg == `ISRC_OFF_TMR_LO);
    wire wr_th  = wr_go & (waddr_reg == `ISRC_OFF_TMR_HI);

    // request gating and priority split
    wire prio_on = rc_reg[`ISRC_RC_PRIO];
    wire req0 = ca_reg[`ISRC_A_INT0F] & ca_reg[`ISRC_A_INT0E];
    wire req1 = cc_reg[`ISRC_C_INT1F] & cc_reg[`ISRC_C_INT1E];
    wire req2 = cc_reg[`ISRC_C_INT2F] & cc_reg[`ISRC_C_INT2E];
    wire reqt = ca_reg[`ISRC_A_T0IF] & ca_reg[`ISRC_A_T0IE];
    wire reqp = ca_reg[`ISRC_A_PCF] & ca_reg[`ISRC_A_PCE];
    // zero always high; others by priority bit, one means high
    wire hi_set = req0
        | (req1 & cc_reg[`ISRC_C_EXT_ONE_PRIORITY])
        | (req2 & cc_reg[`ISRC_C_EXT_TWO_PRIORITY])
        | (reqt & cb_reg[`ISRC_B_T0IP])
        | (reqp & cb_reg[`ISRC_B_PCIP]);
    wire any_req = req0 | req1 | req2 | reqt | reqp;
    wire lo_set = (req1 | req2 | reqt | reqp) & ~hi_set;
    wire global_irq_enable = ca_reg[`ISRC_A_GIE];
    // pins are core-side sources; timer and change are peripheral-gated
    // in compatibility mode
    wire compat_req = req0 | req1 | req2
        | ((reqt | reqp) & ca_reg[`ISRC_A_PERIPHERAL_IRQ_GATE]);

    // flag and control registers; hardware set beats software clear
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ca_reg   <= 8'h00;
            cb_reg   <= `ISRC_RST_CTRL_B;
            cc_reg   <= `ISRC_RST_CTRL_C;
            chg_en_reg <= 4'h0;
            tcfg_reg <= `ISRC_RST_TMR_CFG;
            tmr_reg  <= 16'h0000;
            sleep_reg <= 1'b0;
        end else begin
            if (wr_ca)
                ca_reg <= lane(ca_reg, wd[7:0], wl);
            if (wr_go && waddr_reg == `ISRC_OFF_CTRL_B)
                cb_reg <= lane(cb_reg, wd[7:0], wl);
            if (wr_cc)
                cc_reg <= lane(cc_reg, wd[7:0], wl);
            if (wr_go && waddr_reg == `ISRC_OFF_CHG_EN && wl)
                chg_en_reg <= wd[3:0];
            if (wr_go && waddr_reg == `ISRC_OFF_TMR_CFG)
                tcfg_reg <= lane(tcfg_reg, wd[7:0], wl);
            // flags are held until software writes them low
            if (hit0)
                ca_reg[`ISRC_A_INT0F] <= 1'b1;
            if (hit1)
                cc_reg[`ISRC_C_INT1F] <= 1'b1;
            if (hit2)
                cc_reg[`ISRC_C_INT2F] <= 1'b1;
            if (tmr_ovf)
                ca_reg[`ISRC_A_T0IF] <= 1'b1;
            if (chg_hit)
                ca_reg[`ISRC_A_PCF] <= 1'b1;
            // timer count: bus write wins over increment
            if (wr_tl || wr_th) begin
                tmr_reg[7:0]  <= wr_tl && wl ? wd[7:0] : tmr_reg[7:0];
                tmr_reg[15:8] <= wr_th && wl ? wd[7:0] : tmr_reg[15:8];
            end else if (run) begin
                if (wide)
                    tmr_reg <= tmr_reg + 16'h0001;
                else
                    tmr_reg[7:0] <= tmr_reg[7:0] + 8'h01;
            end
            // sleep entry by software; any enabled request ends it
            if (wr_go && waddr_reg == `ISRC_OFF_CORE && wl)
                sleep_reg <= wd[`ISRC_CORE_SLEEP];
            else if (sleep_reg && any_req)
                sleep_reg <= 1'b0;
        end
    end

    // reset cause register; reset-time values caught after release
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rc_reg   <= 8'h00;
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
            if (boot_reg) begin
                // values depend on strap and reset kind
                rc_reg[`ISRC_RC_SBOR]  <= bor_default;
                rc_reg[`ISRC_RC_POR]   <= ~por_event;
                rc_reg[`ISRC_RC_BOR]   <= ~por_event;
                rc_reg[`ISRC_RC_SWRST] <= 1'b1;
                rc_reg[`ISRC_RC_WDOG]  <= 1'b1;
                rc_reg[`ISRC_RC_SLEEP] <= 1'b1;
            end else begin
                if (wr_rc && wl) begin
                    rc_reg[`ISRC_RC_PRIO] <= wd[`ISRC_RC_PRIO];
                    rc_reg[`ISRC_RC_SBOR] <= wd[`ISRC_RC_SBOR];
                    rc_reg[`ISRC_RC_SWRST] <= wd[`ISRC_RC_SWRST];
                    rc_reg[`ISRC_RC_POR]  <= wd[`ISRC_RC_POR];
                    rc_reg[`ISRC_RC_BOR]  <= wd[`ISRC_RC_BOR];
                end
                // hardware events clear their active-low flags
                if (reset_instr)
                    rc_reg[`ISRC_RC_SWRST] <= 1'b0;
                if (wdog_expired)
                    rc_reg[`ISRC_RC_WDOG] <= 1'b0;
                if (wr_go && waddr_reg == `ISRC_OFF_CORE && wl &&
                    wd[`ISRC_CORE_SLEEP])
                    rc_reg[`ISRC_RC_SLEEP] <= 1'b0;
            end
            rc_reg[`ISRC_RC_UNUSED] <= 1'b0;
        end
    end

    // request outputs and wake decision
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_high    <= 1'b0;
            irq_low     <= 1'b0;
            wake_req    <= 1'b0;
            vector_take <= 1'b0;
        end else begin
            if (prio_on) begin
                irq_high <= global_irq_enable & hi_set;
                irq_low  <= ca_reg[`ISRC_A_PERIPHERAL_IRQ_GATE] & lo_set;
            end else begin
                irq_high <= global_irq_enable & compat_req;
                irq_low  <= 1'b0;
            end
            wake_req    <= sleep_reg & any_req;
            vector_take <= sleep_reg & any_req & global_irq_enable;
        end
    end

    // context save on interrupt entry; stack saturates at depth
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sp_reg     <= 5'd0;
            shadow_reg <= 24'h00_0000;
        end else if (irq_ack) begin
            shadow_reg <= {core_bank, core_status, core_acc};
            if (sp_reg < STK_D[4:0])
                sp_reg <= sp_reg + 5'd1;
        end
    end

    // stack memory has no reset, so it sits in its own process
    always @(posedge clk_sys) begin
        if (irq_ack && sp_reg < STK_D[4:0])
            stack_mem[sp_reg] <= core_pc;
    end

    // read mux
    reg [31:0] rmux;
    reg        rhit;
    always @* begin
        rmux = 32'h0000_0000;
        rhit = 1'b1;
        case (s_axi_araddr)
            `ISRC_OFF_CAUSE:   rmux[7:0] = rc_reg;
            `ISRC_OFF_CTRL_A:  rmux[7:0] = ca_reg;
            `ISRC_OFF_CTRL_B:  rmux[7:0] = cb_reg;
            `ISRC_OFF_CTRL_C:  rmux[7:0] = cc_reg;
            `ISRC_OFF_CHG_EN:  rmux[3:0] = chg_en_reg;
            `ISRC_OFF_TMR_LO:  rmux[7:0] = tmr_reg[7:0];
            `ISRC_OFF_TMR_HI:  rmux[7:0] = tmr_reg[15:8];
            `ISRC_OFF_TMR_CFG: rmux[7:0] = tcfg_reg;
            `ISRC_OFF_CORE:    rmux[0]   = sleep_reg;
            `ISRC_OFF_SHADOW:  rmux[23:0] = shadow_reg;
            `ISRC_OFF_RET_PC:  rmux[PC_W-1:0] = (sp_reg == 5'd0) ?
                {PC_W{1'b0}} : stack_mem[sp_reg - 5'd1];
            default:           rhit = 1'b0;
        endcase
    end

    // axi4-lite slave: address and data taken in any order
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ISRC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ISRC_RESP_OKAY;
            aw_ok_reg <= 1'b0;
            w_ok_reg  <= 1'b0;
            waddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_reg <= s_axi_awaddr;
                aw_ok_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_ok_reg  <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_ok_reg <= 1'b0;
                w_ok_reg  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped writes get slverr
                s_axi_bresp <= (waddr_reg <= `ISRC_OFF_CORE &&
                    waddr_reg[1:0] == 2'b00) ? `ISRC_RESP_OKAY
                                             : `ISRC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rmux;
                s_axi_rresp   <= rhit ? `ISRC_RESP_OKAY
                                      : `ISRC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // isrc_top

// [verification/isrc_properties.sv]
// concurrent checks for isrc
`timescale 1ns/1ps
module isrc_checker #(parameter PC_W = 21) (
    input logic            clk_sys, rstn, irq_ack, irq_high, irq_low,
    input logic [PC_W-1:0] core_pc,
    input logic [7:0]      core_acc, core_status, core_bank,
    input logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input logic            s_axi_wready, s_axi_bvalid,
    input logic [11:0]     s_axi_araddr,
    input logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input logic [31:0]     s_axi_rdata,
    input logic [1:0]      s_axi_rresp
);
    logic [11:0]     ra;     // read address
    logic [23:0]     ctx;    // last saved context
    logic [PC_W-1:0] pc_top; // last pushed pc
    logic            seen;   // entry seen
    // track read address and last entry
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ra <= 12'h000;
            ctx <= 24'h00_0000;
            pc_top <= '0;
            seen <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (irq_ack) begin
                ctx <= {core_bank, core_status, core_acc};
                pc_top <= core_pc;
                seen <= 1'b1;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:4] s_axi_rvalid) else $error("read not answered");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write not answered");
    a_wr_busy: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write open");
    a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read open");
    a_cause_gap: assert property (s_axi_rvalid && ra == 12'h000
        |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[5])
        else $error("cause bit five set");
    a_bad_addr: assert property (s_axi_rvalid && (ra > 12'h028 ||
        ra[1:0] != 2'b00) |-> s_axi_rresp == 2'h2)
        else $error("unmapped read accepted");
    a_ctx_copy: assert property (s_axi_rvalid && seen
        && ra == 12'h024 |-> s_axi_rdata[23:0] == ctx)
        else $error("shadow copy wrong");
    a_pc_push: assert property (s_axi_rvalid && seen
        && ra == 12'h028 |-> s_axi_rdata[PC_W-1:0] == pc_top)
        else $error("return address wrong");
    a_quiet_exit: assert property (!$past(rstn)
        |-> !irq_high && !irq_low) else $error("irq out of reset");
    c_high: cover property ($rose(irq_high));
    c_low: cover property ($rose(irq_low));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // isrc_checker

// [verification/isrc_core_model.sv]
// core and pin model for isrc
`timescale 1ns/1ps
module isrc_core_model (
    input  logic        clk_sys,     // system clock
    output logic [2:0]  ext_pins,    // external pins
    output logic [3:0]  port_b_hi,   // upper port-B pins
    output logic [20:0] core_pc,     // return address
    output logic [7:0]  core_acc,    // working accumulator
    output logic [7:0]  core_status, // status register
    output logic [7:0]  core_bank,   // bank select register
    output logic        irq_ack      // entry strobe
);
    // pins idle low, context starts cleared
    initial begin
        ext_pins = 3'h0;
        port_b_hi = 4'h0;
        core_pc = 21'h0_0000;
        {core_bank, core_status, core_acc} = 24'h00_0000;
        irq_ack = 1'b0;
    end
    // set one pin, just after an edge
    task pin(input int p, input logic v);
        ext_pins[p] <= v;
    endtask
    // toggle one upper port-B pin
    task flip(input int k);
        port_b_hi[k] <= ~port_b_hi[k];
    endtask
    // context moves on after entry, exposing a late capture
    task enter(input logic [20:0] pc, input logic [23:0] c,
               input int lat);
        repeat (lat) @(posedge clk_sys);
        core_pc <= pc;
        {core_bank, core_status, core_acc} <= c;
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        core_pc <= ~pc;
        {core_bank, core_status, core_acc} <= ~c;
    endtask
endmodule // isrc_core_model

// [verification/irq_sources_and_reset_cause_test.sv]
// self-checking bench for isrc
`timescale 1ns/1ps
`include "isrc_map.vh"
module irq_sources_and_reset_cause_test;
    logic        clk_sys = 1'b0, rstn = 1'b0;  // clock, reset
    logic        por_event = 1'b1, bor_default = 1'b1; // straps
    logic        reset_instr = 1'b0, wdog_expired = 1'b0;
    logic        timer_tick = 1'b0;
    logic [2:0]  ext_pins;            // driven by the core model
    logic [3:0]  port_b_hi;
    logic [20:0] core_pc;
    logic [7:0]  core_acc, core_status, core_bank;
    logic        irq_ack, irq_high, irq_low, wake_req, vector_take;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;  // registers sit in byte 0
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fail_count = 0, n_checks = 0;
    // register, flag and enable of each external pin
    logic [11:0] fa[3] = '{`ISRC_OFF_CTRL_A, `ISRC_OFF_CTRL_C,
                           `ISRC_OFF_CTRL_C};
    logic [7:0]  fm[3] = '{8'h02, 8'h01, 8'h02};
    logic [7:0]  em[3] = '{8'h10, 8'h08, 8'h10};
    isrc_top dut_u (.*);
    isrc_core_model m_u (.*);
    always #4 clk_sys = ~clk_sys;
    // cause value after reset
    function automatic logic [31:0] cause_rst(input logic por, bor);
        return 32'({1'b0, bor, 4'b0111, {2{~por}}});
    endfunction
    // pin zero always high, others by priority bit
    function automatic logic hi_exp(input int p, input logic pr);
        return (p == 0) || pr;
    endfunction
    task chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // each channel is released at the edge that takes it
    task wr(input logic [11:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'(d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask
    task ticks(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge clk_sys);
        timer_tick <= 1'b0;
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a hang anywhere ends the run as a mismatch
    initial begin
        #400_000;
        fail_count++;
        close_out();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  b;
        logic [3:0]  m;
        logic [23:0] c;
        logic [20:0] pc;
        int          x;
        void'($urandom(59219));
        cyc(6);
        rstn <= 1'b1;
        cyc(3);
        rc("cause", `ISRC_OFF_CAUSE, cause_rst(1'b1, 1'b1));
        rc("ctrl_b", `ISRC_OFF_CTRL_B, 32'h0000_007F);
        rc("ctrl_c", `ISRC_OFF_CTRL_C, 32'h0000_00C0);
        rd(12'h02C, d, r);
        chk("unmapped", 32'(`ISRC_RESP_SLVERR), 32'(r));
        rd(12'h006, d, r);
        chk("misaligned", 32'(`ISRC_RESP_SLVERR), 32'(r));
        wr(`ISRC_OFF_CAUSE, 8'hFF);
        rc("cause wr", `ISRC_OFF_CAUSE, 32'h0000_00DF);
        reset_instr <= 1'b1;
        cyc(1);
        reset_instr <= 1'b0;
        rc("reset instr", `ISRC_OFF_CAUSE, 32'h0000_00CF);
        wdog_expired <= 1'b1;
        cyc(1);
        wdog_expired <= 1'b0;
        rc("watchdog", `ISRC_OFF_CAUSE, 32'h0000_00C7);
        // each pin and edge sense, priority on
        for (int p = 0; p < 3; p++) begin
            for (int e = 0; e < 2; e++) begin
                wr(`ISRC_OFF_CTRL_B, e ? 8'h7F : 8'h0F);
                b = (p == 0 || e) ? 8'hC0 : 8'h00;
                wr(fa[p], b);
                m_u.pin(p, !e);
                cyc(6);
                rc("wrong edge", fa[p], 32'(b));
                wr(fa[p], b | em[p]);
                m_u.pin(p, e[0]);
                cyc(6);
                rc("edge flag", fa[p], 32'(b | em[p] | fm[p]));
                chk("high", 32'(hi_exp(p, e[0])), 32'(irq_high));
                chk("low", 32'(!hi_exp(p, e[0])), 32'(irq_low));
                wr(fa[p], b | fm[p]);
                cyc(2);
                chk("masked", 32'h0, 32'({irq_high, irq_low}));
                rc("held", fa[p], 32'(b | fm[p]));
            end
        end
        // timer rollover, priority levels off
        wr(`ISRC_OFF_CAUSE, 8'h00);
        wr(`ISRC_OFF_CTRL_A, 8'hA0);
        wr(`ISRC_OFF_TMR_CFG, 8'h02);
        x = $urandom_range(254, 0);
        wr(`ISRC_OFF_TMR_LO, 8'(x));
        ticks(255 - x);
        rc("t8 early", `ISRC_OFF_CTRL_A, 32'h0000_00A0);
        ticks(1);
        rc("t8 wrap", `ISRC_OFF_CTRL_A, 32'h0000_00A4);
        chk("no gate", 32'h0, 32'(irq_high));
        wr(`ISRC_OFF_CTRL_A, 8'hE4);
        cyc(2);
        chk("gate", 32'h1, 32'(irq_high));
        wr(`ISRC_OFF_CTRL_A, 8'h00);
        wr(`ISRC_OFF_TMR_CFG, 8'h03);
        wr(`ISRC_OFF_TMR_HI, 8'hFE);
        wr(`ISRC_OFF_TMR_LO, 8'(x));
        ticks(256 - x);
        rc("t16 low wrap", `ISRC_OFF_CTRL_A, 32'h0);
        ticks(255);
        rc("t16 early", `ISRC_OFF_CTRL_A, 32'h0);
        ticks(1);
        rc("t16 wrap", `ISRC_OFF_CTRL_A, 32'h0000_0004);
        // change on each upper pin, random mask
        m = 4'($urandom_range(14, 1));
        wr(`ISRC_OFF_CHG_EN, 8'(m));
        for (int k = 0; k < 4; k++) begin
            wr(`ISRC_OFF_CTRL_A, 8'h08);
            m_u.flip(k);
            cyc(6);
            rc("change", `ISRC_OFF_CTRL_A, 32'(8'h08 | m[k]));
        end
        c = 24'($urandom);
        pc = 21'($urandom);
        m_u.enter(pc, c, $urandom_range(3, 0));
        rc("shadow", `ISRC_OFF_SHADOW, 32'(c));
        rc("ret pc", `ISRC_OFF_RET_PC, 32'(pc));
        // wake on pin zero, with and without global enable
        for (int g = 0; g < 2; g++) begin
            m_u.pin(0, 1'b0);
            wr(`ISRC_OFF_CTRL_A, g ? 8'h90 : 8'h10);
            wr(`ISRC_OFF_CORE, 8'h01);
            m_u.pin(0, 1'b1);
            while (!wake_req) @(posedge clk_sys);
            chk("vector", 32'(g), 32'(vector_take));
            rc("awake", `ISRC_OFF_CORE, 32'h0);
        end
        close_out();
    end
endmodule // irq_sources_and_reset_cause_test
bind isrc_top isrc_checker #(.PC_W(PC_W)) chk_u (.*);
